/* File: rcl_loader.sv */
// Configuration sequencer with remote/local update, user watchdog and AHB-Lite registers.
// Assumes load stream and reconfig/chain pins are asynchronous to mclk; wd_restart is not.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module rcl_loader
    import rcl_pkg::*;
#(
    parameter int LOAD_LIMIT = LOAD_LIMIT_CYC
)(
    input  wire logic        mclk,              // System clock, 100 MHz
    input  wire logic        rst_n,             // Power-up reset, async, active low
    input  wire logic        hsel,              // AHB-Lite slave select
    input  wire logic [7:0]  haddr,             // AHB-Lite byte address
    input  wire logic [1:0]  htrans,            // AHB-Lite transfer type
    input  wire logic        hwrite,            // AHB-Lite write
    input  wire logic [2:0]  hsize,             // AHB-Lite size
    input  wire logic [31:0] hwdata,            // AHB-Lite write data
    input  wire logic        hready,            // AHB-Lite bus ready
    output logic             hreadyout,         // Always ready
    output logic             hresp,             // Always OKAY
    output logic [31:0]      hrdata,            // Read data
    input  wire logic        remote_mode,       // 1 remote update, 0 local update
    input  wire logic [1:0]  scheme,            // Loading scheme
    input  wire logic        host_page_mode,    // Async host supports page selection
    input  wire logic        reconfig_n,        // Reconfig pin, active low
    input  wire logic        chain_enable_in_n, // Chain enable in, active low
    output logic             chain_enable_out_n,// Chain enable out, active low
    input  wire rcl_load_t   load_in,           // Load stream from memory or host
    output logic             load_req,          // Requesting image data
    output logic [PAGE_W-1:0] load_page,        // Page being fetched
    output logic             init_clear,        // Clears user registers during init
    output logic             user_io_oe,        // User pins driven
    output logic             user_mode,         // In user mode
    input  wire logic        wd_restart,        // Watchdog restart from user logic
    output logic             irq                // Level interrupt
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam int SYN_W = 13;
    localparam logic [SYN_W-1:0] SYN_RST = 13'h1800;

    logic [SYN_W-1:0] syn1_ff;
    logic [SYN_W-1:0] syn2_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syn1_ff <= SYN_RST;
            syn2_ff <= SYN_RST;
        end
        else
        begin
            syn1_ff <= {reconfig_n, chain_enable_in_n, load_in};
            syn2_ff <= syn1_ff;
        end
    end

    wire       rcfg_low  = !syn2_ff[12];
    wire       chain_ok  = !syn2_ff[11];
    rcl_load_t ld;
    assign ld = syn2_ff[10:0];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    rcl_state_t        state_ff;
    rcl_state_t        nxt_state;
    logic [31:0]       ctrl_ff;
    logic [31:0]       wdto_ff;
    logic [PAGE_W-1:0] page_ff;
    logic [PAGE_W-1:0] nxt_page;
    logic [1:0]        cause_ff;
    logic              scherr_ff;
    logic              wd_act_ff;
    logic [31:0]       wd_cnt_ff;
    logic [31:0]       ld_cnt_ff;
    logic [2:0]        init_cnt_ff;
    logic [IRQ_W-1:0]  irq_stat_ff;
    logic [IRQ_W-1:0]  irq_en_ff;
    logic              wr_pend_ff;
    logic [7:0]        wr_addr_ff;
    logic [31:0]       hrdata_ff;

    // ----------------------------------------------------------------
    // Sequencer decode
    // ----------------------------------------------------------------
    wire is_factory  = (page_ff == FACTORY_PAGE);
    wire sch_bad     = (scheme == SCH_PAR_ASYNC) && remote_mode && !host_page_mode;
    wire ld_timeout  = (ld_cnt_ff >= 32'(LOAD_LIMIT - 1));
    wire ld_fail     = (state_ff == ST_LOAD) && ((ld.valid && ld.err) || ld_timeout);
    wire ld_done     = (state_ff == ST_LOAD) && ld.valid && ld.last && !ld.err;
    wire wd_expire   = (state_ff == ST_USER) && wd_act_ff && !wd_restart
                       && (wd_cnt_ff >= wdto_ff);
    wire pin_rcfg    = (state_ff != ST_WAIT) && rcfg_low;
    wire init_end    = (state_ff == ST_INIT) && (init_cnt_ff == 3'(INIT_CYC - 1));
    wire wr_now      = wr_pend_ff;
    wire go_write    = wr_now && (wr_addr_ff == OFF_CTRL) && hwdata[CTRL_GO_BIT];
    wire sw_rcfg     = go_write && (state_ff == ST_USER) && is_factory && remote_mode;
    wire boot_page_w = remote_mode ? 1'b1 : 1'b0;
    wire [PAGE_W-1:0] boot_page = boot_page_w ? FACTORY_PAGE : LOCAL_APP_PAGE;
    // GO takes its page from the same write, since ctrl_ff only updates at that edge
    wire [PAGE_W-1:0] ctrl_page = go_write ? hwdata[PAGE_W-1:0]
                                           : ctrl_ff[PAGE_W-1:0];

    always_comb
    begin
        nxt_state = state_ff;
        nxt_page  = page_ff;
        case (state_ff)
            ST_WAIT:
            begin
                if (chain_ok && !rcfg_low && !sch_bad)
                begin
                    nxt_state = ST_LOAD;
                    // Page 0 after power-up becomes the app page in local mode
                    nxt_page  = is_factory ? boot_page : page_ff;
                end
            end
            ST_LOAD:
            begin
                if (pin_rcfg)
                begin
                    nxt_state = ST_WAIT;
                end
                else if (ld_fail)
                begin
                    nxt_state = ST_WAIT;
                    nxt_page  = remote_mode ? FACTORY_PAGE : page_ff;
                end
                else if (ld_done)
                begin
                    nxt_state = ST_INIT;
                end
            end
            ST_INIT:
            begin
                if (pin_rcfg)
                begin
                    nxt_state = ST_WAIT;
                end
                else if (init_end)
                begin
                    nxt_state = ST_USER;
                end
            end
            ST_USER:
            begin
                if (pin_rcfg)
                begin
                    nxt_state = ST_WAIT;
                end
                else if (wd_expire)
                begin
                    nxt_state = ST_WAIT;
                    nxt_page  = FACTORY_PAGE;
                end
                else if (sw_rcfg)
                begin
                    nxt_state = ST_WAIT;
                    nxt_page  = ctrl_page;
                end
            end
            default:
            begin
                nxt_state = ST_WAIT;
            end
        endcase
    end

    // Leaving WAIT after a fallback keeps the chosen page; a pin reload restarts at boot page
    wire [PAGE_W-1:0] wait_page = (state_ff == ST_WAIT) ? nxt_page : page_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_WAIT;
            page_ff  <= FACTORY_PAGE;
        end
        else
        begin
            state_ff <= nxt_state;
            page_ff  <= (pin_rcfg) ? boot_page : nxt_page;
        end
    end

    // ----------------------------------------------------------------
    // Counters, cause and watchdog
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ld_cnt_ff   <= 32'h0000_0000;
            init_cnt_ff <= 3'h0;
            wd_cnt_ff   <= 32'h0000_0000;
            wd_act_ff   <= 1'b0;
            cause_ff    <= CAUSE_NONE;
            scherr_ff   <= 1'b0;
        end
        else
        begin
            ld_cnt_ff   <= (state_ff == ST_LOAD) ? ld_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
            init_cnt_ff <= (state_ff == ST_INIT) ? init_cnt_ff + 3'h1 : 3'h0;
            wd_cnt_ff   <= (state_ff == ST_USER && !wd_restart)
                           ? wd_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
            if (state_ff == ST_WAIT && nxt_state == ST_LOAD)
                wd_act_ff <= ctrl_ff[CTRL_WDEN_BIT] && remote_mode
                             && (wait_page != FACTORY_PAGE);
            scherr_ff   <= sch_bad;
            // Only power-up clears the cause, so factory logic can read it
            if (ld_fail && remote_mode)
                cause_ff <= CAUSE_LOAD;
            else if (wd_expire)
                cause_ff <= CAUSE_WDOG;
            else if (pin_rcfg && state_ff == ST_USER)
                cause_ff <= CAUSE_PIN;
        end
    end

    // ----------------------------------------------------------------
    // Device pins
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_req           <= 1'b0;
            load_page          <= FACTORY_PAGE;
            init_clear         <= 1'b0;
            user_io_oe         <= 1'b0;
            user_mode          <= 1'b0;
            chain_enable_out_n <= 1'b1;
        end
        else
        begin
            load_req           <= (nxt_state == ST_LOAD);
            load_page          <= (state_ff == ST_WAIT) ? wait_page : page_ff;
            init_clear         <= (nxt_state == ST_INIT);
            user_io_oe         <= (nxt_state == ST_USER);
            user_mode          <= (nxt_state == ST_USER);
            chain_enable_out_n <= !(nxt_state == ST_USER);
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------------------------------
    wire addr_ph = hsel && hready && htrans[1];
    wire [31:0] status_w = {16'h0000, state_ff, 3'h0, wd_act_ff, scherr_ff, is_factory,
                            cause_ff, 1'b0, page_ff};
    wire [31:0] rd_mux =
        (haddr == OFF_CTRL)     ? ctrl_ff :
        (haddr == OFF_WDTO)     ? wdto_ff :
        (haddr == OFF_STATUS)   ? status_w :
        (haddr == OFF_IRQ_STAT) ? {29'h0, irq_stat_ff} :
        (haddr == OFF_IRQ_EN)   ? {29'h0, irq_en_ff} : 32'h0000_0000;
    wire [IRQ_W-1:0] irq_ev  = {(nxt_state == ST_USER) && (state_ff != ST_USER),
                                wd_expire, ld_fail};
    wire [IRQ_W-1:0] irq_clr = (wr_now && wr_addr_ff == OFF_IRQ_CLR) ? hwdata[IRQ_W-1:0]
                                                                     : {IRQ_W{1'b0}};

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_ff  <= 1'b0;
            wr_addr_ff  <= 8'h00;
            hrdata_ff   <= 32'h0000_0000;
            ctrl_ff     <= CTRL_RST;
            wdto_ff     <= WDTO_RST;
            irq_en_ff   <= {IRQ_W{1'b0}};
            irq_stat_ff <= {IRQ_W{1'b0}};
        end
        else
        begin
            wr_pend_ff  <= addr_ph && hwrite;
            wr_addr_ff  <= haddr;
            if (addr_ph && !hwrite)
                hrdata_ff <= rd_mux;
            if (wr_now && wr_addr_ff == OFF_CTRL)
                ctrl_ff <= hwdata & ~(32'h0000_0001 << CTRL_GO_BIT);
            if (wr_now && wr_addr_ff == OFF_WDTO)
                wdto_ff <= hwdata;
            if (wr_now && wr_addr_ff == OFF_IRQ_EN)
                irq_en_ff <= hwdata[IRQ_W-1:0];
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign irq       = |(irq_stat_ff & irq_en_ff);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic booted_ff;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            booted_ff <= 1'b0;
        else if (state_ff == ST_LOAD)
            booted_ff <= 1'b1;
    end

    sequence s_first_start;
        (state_ff == ST_WAIT) && !booted_ff && remote_mode ##1 (state_ff == ST_LOAD);
    endsequence

    property p_first_page;
        s_first_start |-> (page_ff == FACTORY_PAGE) && load_req;
    endproperty
    a_first_page: assert property (p_first_page)
        else $error("first remote load not from factory page");

    property p_fallback;
        ld_fail && remote_mode && !pin_rcfg |=> (page_ff == FACTORY_PAGE)
            && (cause_ff == CAUSE_LOAD) && (state_ff == ST_WAIT);
    endproperty
    a_fallback: assert property (p_fallback)
        else $error("failed load did not fall back with cause");

    property p_wd_expire;
        wd_expire && !pin_rcfg |=> (cause_ff == CAUSE_WDOG) && (page_ff == FACTORY_PAGE)
            ##1 (state_ff != ST_USER);
    endproperty
    a_wd_expire: assert property (p_wd_expire)
        else $error("watchdog expiry did not reload factory image");

    property p_factory_no_wd;
        (state_ff == ST_USER) && is_factory |-> !wd_act_ff;
    endproperty
    a_factory_no_wd: assert property (p_factory_no_wd)
        else $error("watchdog active under factory image");

    property p_io_hiz;
        (state_ff != ST_USER) |=> !user_io_oe || $past(nxt_state == ST_USER);
    endproperty
    a_io_hiz: assert property (p_io_hiz)
        else $error("user pins driven outside user mode");

    sequence s_init_run;
        ((state_ff == ST_INIT) && !pin_rcfg) [*4];
    endsequence

    property p_init_then_user;
        $rose(state_ff == ST_INIT) ##0 s_init_run |=> (state_ff == ST_USER) && user_io_oe;
    endproperty
    a_init_then_user: assert property (p_init_then_user)
        else $error("init did not lead to user mode");

    property p_pin_reload;
        (state_ff == ST_USER) && rcfg_low |=> (state_ff == ST_WAIT) && !user_mode;
    endproperty
    a_pin_reload: assert property (p_pin_reload)
        else $error("reconfig pin did not leave user mode");

    property p_chain_out;
        !chain_enable_out_n |-> user_mode;
    endproperty
    a_chain_out: assert property (p_chain_out)
        else $error("chain enable out asserted before configured");

    property p_load_limit;
        (state_ff == ST_LOAD) |-> ld_cnt_ff < 32'(LOAD_LIMIT);
    endproperty
    a_load_limit: assert property (p_load_limit)
        else $error("load exceeded time limit");

    property p_local_direct;
        !remote_mode && (state_ff == ST_WAIT) && !booted_ff ##1 (state_ff == ST_LOAD)
            |-> (page_ff == LOCAL_APP_PAGE);
    endproperty
    a_local_direct: assert property (p_local_direct)
        else $error("local mode did not load the application directly");

    property p_cause_kept;
        (cause_ff != CAUSE_NONE) |=> (cause_ff != CAUSE_NONE);
    endproperty
    a_cause_kept: assert property (p_cause_kept)
        else $error("status cause lost across reconfiguration");

endmodule

/* File: rcl_loader_test.sv */
// Self-checking bench: boot, watchdog, load fallback, reconfig pin, local mode.
// Assumes rcl_mem_model supplies the images; page 5 is corrupt.
`timescale 1ns/100ps
module rcl_loader_test;
    import rcl_pkg::*;
    logic        mclk        = 1'b0;
    logic        rst_n       = 1'b0;
    logic [7:0]  haddr       = 8'h00;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [31:0] hwdata      = 32'h0;
    logic        remote_mode = 1'b1;
    logic        reconfig_n  = 1'b1;
    logic        wd_restart  = 1'b0;
    logic        chain_enable_in_n = 1'b1;
    logic        hresp;
    logic [31:0] hrdata, rdata;
    logic [2:0]  load_page;
    logic        hreadyout, load_req, chain_enable_out_n, init_clear, user_io_oe;
    logic        user_mode, irq;
    rcl_load_t   load_in;
    int          bad_count   = 0;
    int          checked     = 0;

    rcl_loader #(.LOAD_LIMIT(200)) rcl_loader_inst (
        .mclk(mclk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .remote_mode(remote_mode),
        .scheme(SCH_SERIAL), .host_page_mode(1'b0), .reconfig_n(reconfig_n),
        .chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(chain_enable_out_n),
        .load_in(load_in), .load_req(load_req), .load_page(load_page),
        .init_clear(init_clear), .user_io_oe(user_io_oe), .user_mode(user_mode),
        .wd_restart(wd_restart), .irq(irq));
    rcl_mem_model rcl_mem_model_inst (.mclk(mclk), .load_req(load_req),
        .load_page(load_page), .bad_pages(8'h20), .load_in(load_in));

    initial forever #5 mclk = ~mclk;

    task automatic summarize();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        summarize();
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Ends at the rising edge at which hready is sampled high
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
            hang();
    endtask
    // Single word transfer; read data lands in rdata
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rdata = hrdata;
    endtask
    task automatic wait_mode(input logic v);
        int n;
        for (n = 0; n < 600 && user_mode !== v; n++)
            @(negedge mclk);
        if (n == 600)
            hang();
    endtask
    // Expected status word in user mode
    function automatic logic [15:0] st(input logic [2:0] pg, input logic [1:0] c,
                                       input logic f, input logic w);
        st = 16'h8000 | 16'(pg) | (16'(c) << ST_CAUSE_LSB) | (16'(f) << ST_FACT_BIT)
             | (16'(w) << ST_WDACT_BIT);
    endfunction
    task automatic do_reset(input logic m);
        @(posedge mclk);
        rst_n <= 1'b0;
        remote_mode <= m;
        chain_enable_in_n <= 1'b1;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(negedge mclk);
        chk(16'({load_req, chain_enable_out_n}), 16'h1);
        @(posedge mclk);
        chain_enable_in_n <= 1'b0;
        repeat (6) @(negedge mclk);
    endtask
    task automatic s_boot(input logic m);
        int n;
        chk(16'(user_io_oe), 16'h0);
        chk(16'(load_page), m ? 16'h0 : 16'h1);
        for (n = 0; n < 50 && init_clear !== 1'b1; n++)
            @(negedge mclk);
        chk(16'({init_clear, user_io_oe}), 16'h2);
        wait_mode(1'b1);
        chk(16'(user_io_oe), 16'h1);
        chk(16'(chain_enable_out_n), 16'h0);
        ahb(1'b0, OFF_STATUS, 32'h0);
        chk(rdata[15:0], st(m ? 3'h0 : 3'h1, CAUSE_NONE, m, 1'b0));
    endtask
    task automatic s_wdog();
        ahb(1'b1, OFF_WDTO, 32'h0000_0028);
        ahb(1'b1, OFF_IRQ_EN, 32'h0000_0007);
        ahb(1'b1, OFF_CTRL, 32'h0000_0113);
        wait_mode(1'b0);
        wait_mode(1'b1);
        ahb(1'b0, OFF_STATUS, 32'h0);
        chk(rdata[15:0], st(3'h3, CAUSE_NONE, 1'b0, 1'b1));
        wd_restart <= 1'b1;
        repeat (100) @(negedge mclk);
        chk(16'(user_mode), 16'h1);
        @(posedge mclk);
        wd_restart <= 1'b0;
        wait_mode(1'b0);
        wait_mode(1'b1);
        ahb(1'b0, OFF_STATUS, 32'h0);
        chk(rdata[15:0], st(3'h0, CAUSE_WDOG, 1'b1, 1'b0));
        chk(16'(irq), 16'h1);
        ahb(1'b1, OFF_IRQ_CLR, 32'h0000_0007);
        @(negedge mclk);
        chk(16'(irq), 16'h0);
    endtask
    task automatic s_fail();
        ahb(1'b1, OFF_CTRL, 32'h0000_0105);
        wait_mode(1'b0);
        wait_mode(1'b1);
        ahb(1'b0, OFF_STATUS, 32'h0);
        chk(rdata[15:0], st(3'h0, CAUSE_LOAD, 1'b1, 1'b0));
        ahb(1'b0, OFF_IRQ_STAT, 32'h0);
        chk({13'h0, rdata[2:0]}, 16'h0005);
    endtask
    task automatic s_pin();
        @(posedge mclk);
        reconfig_n <= 1'b0;
        wait_mode(1'b0);
        @(posedge mclk);
        reconfig_n <= 1'b1;
        wait_mode(1'b1);
        ahb(1'b0, OFF_STATUS, 32'h0);
        chk(rdata[15:0], st(3'h0, CAUSE_PIN, 1'b1, 1'b0));
        ahb(1'b0, 8'h20, 32'h0);
        chk(rdata[15:0], 16'h0000);
        chk(16'(hresp), 16'h0);
    endtask

    initial
    begin
        do_reset(1'b1);
        s_boot(1'b1);
        s_wdog();
        s_fail();
        s_pin();
        do_reset(1'b0);
        s_boot(1'b0);
        summarize();
    end
endmodule

/* File: rcl_mem_model.sv */
// Paged configuration memory model that streams eight-beat images.
// Assumes load_req and load_page come from the loader on mclk.
`timescale 1ns/100ps
module rcl_mem_model
    import rcl_pkg::*;
(
    input  wire logic       mclk,      // System clock
    input  wire logic       load_req,  // Loader asks for data
    input  wire logic [2:0] load_page, // Page asked for
    input  wire logic [7:0] bad_pages, // Pages whose image is corrupt
    output rcl_load_t       load_in    // Beat stream
);
    int cnt = 0;
    initial load_in = '0;
    // Read-only pages, page 0 is never rewritten; serial byte beats
    always @(posedge mclk)
    begin
        cnt <= load_req ? cnt + 1 : 0;
        load_in.valid <= load_req && cnt < 8;
        load_in.last <= cnt == 7;
        load_in.err <= cnt == 7 && bad_pages[load_page];
        load_in.data <= load_req ? cnt[7:0] : ~load_in.data;
    end
endmodule

/* File: rcl_pkg.sv */
// Constants, types and register map of the remote-update configuration loader.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register port.
package rcl_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_WDTO     = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h14;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          PAGE_W         = 3;
    localparam int          CTRL_WDEN_BIT  = 4;
    localparam int          CTRL_GO_BIT    = 8;
    localparam int          ST_CAUSE_LSB   = 4;
    localparam int          ST_FACT_BIT    = 6;
    localparam int          ST_SCHERR_BIT  = 7;
    localparam int          ST_WDACT_BIT   = 8;
    localparam int          ST_STATE_LSB   = 12;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0001;
    localparam logic [31:0] WDTO_RST       = 32'h0001_0000;
    localparam logic [2:0]  FACTORY_PAGE   = 3'h0;
    localparam logic [2:0]  LOCAL_APP_PAGE = 3'h1;

    // ----------------------------------------------------------------
    // Causes and interrupt bits
    // ----------------------------------------------------------------
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_LOAD = 2'h1;
    localparam logic [1:0] CAUSE_WDOG = 2'h2;
    localparam logic [1:0] CAUSE_PIN  = 2'h3;
    localparam int         IRQ_W      = 3;
    localparam int         IRQ_LOAD   = 0;
    localparam int         IRQ_WDOG   = 1;
    localparam int         IRQ_USER   = 2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int LOAD_LIMIT_MS  = 100;
    localparam int LOAD_LIMIT_CYC = LOAD_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int INIT_CYC       = 4;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SCH_SERIAL    = 2'h0,
        SCH_PAR_SYNC  = 2'h1,
        SCH_PAR_ASYNC = 2'h2
    } rcl_scheme_t;

    typedef enum logic [3:0] {
        ST_WAIT = 4'h1,
        ST_LOAD = 4'h2,
        ST_INIT = 4'h4,
        ST_USER = 4'h8
    } rcl_state_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic       err;
        logic [7:0] data;
    } rcl_load_t;

endpackage
